// file: tb/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   input  wire logic       sys_clk,
   output logic            chipSelect,
   output logic            nRamSelect,
   output logic            readNotWrite,
   output logic      [6:0] addr,
   output logic      [7:0] dataIn,
   input  wire logic [7:0] dataOut
);
   initial begin
      chipSelect = 1'b0;
      nRamSelect = 1'b0;
      readNotWrite = 1'b1;
      addr = 7'h00;
      dataIn = 8'h00;
   end
   // One transfer per call; lines move only on the falling edge
   task automatic access(input logic io, input logic rd, input logic [6:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      @(negedge sys_clk);
      chipSelect = 1'b1;
      nRamSelect = io;
      readNotWrite = rd;
      addr = a;
      dataIn = d;
      @(negedge sys_clk);
      q = dataOut;
      chipSelect = 1'b0;
      // A released bus must not echo the last byte
      dataIn = ~d;
   endtask
endmodule
`default_nettype wire

// file: tb/ram_io_timer_combo_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module io_bus_checker (
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire logic       chipSelect,
   input wire logic       nRamSelect,
   input wire logic       readNotWrite,
   input wire logic [6:0] addr,
   input wire logic [7:0] dataIn,
   input wire logic       dataOe,
   input wire logic [7:0] portAOut,
   input wire logic [7:0] portAOe,
   input wire logic [7:0] portBOut,
   input wire logic       irqOut,
   input wire logic       irqOe
);
   logic rdReq;
   logic wrReq;
   logic dirAWr;
   logic datBWr;
   assign rdReq = chipSelect && readNotWrite;
   assign wrReq = chipSelect && !readNotWrite;
   assign dirAWr = wrReq && nRamSelect && !addr[4] && addr[2:0] == 3'h1;
   assign datBWr = wrReq && nRamSelect && !addr[4] && addr[2:0] == 3'h2;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_read_answers: assert property (rdReq |=> dataOe) else $error("no read answer");
   a_oe_needs_read: assert property (dataOe |-> $past(rdReq)) else $error("bus driven idle");
   a_write_quiet: assert property (wrReq |=> !dataOe) else $error("bus driven on write");
   a_dir_write: assert property (dirAWr |=> portAOe == $past(dataIn)) else $error("dir A");
   a_dir_holds: assert property (!dirAWr |=> $stable(portAOe)) else $error("dir A moved");
   a_latch_write: assert property (datBWr |=> portBOut == $past(dataIn)) else $error("latch B");
   a_irq_drain: assert property (irqOut == 1'b0) else $error("irq pin high");
   a_reset_clears: assert property (disable iff (1'b0) !nrst |-> !dataOe && !irqOe && portAOe == 8'h00
      && portAOut == 8'h00 && portBOut == 8'h00) else $error("reset state");
   c_read: cover property (rdReq ##1 dataOe);
   c_irq: cover property ($rose(irqOe));
   c_dir: cover property (dirAWr);
endmodule
bind ram_io_timer_combo io_bus_checker chk (.sys_clk(sys_clk), .nrst(nrst), .chipSelect(chipSelect),
   .nRamSelect(nRamSelect), .readNotWrite(readNotWrite), .addr(addr), .dataIn(dataIn), .dataOe(dataOe),
   .portAOut(portAOut), .portAOe(portAOe), .portBOut(portBOut), .irqOut(irqOut), .irqOe(irqOe));
`default_nettype wire

// file: tb/ram_io_timer_combo_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ram_io_timer_combo_bench;
   logic       sys_clk, nrst, chipSelect, nRamSelect, readNotWrite, dataOe, irqOut, irqOe;
   logic [6:0] addr;
   logic [7:0] dataIn, dataOut, portAIn, portAOut, portAOe, portBIn, portBOut, portBOe, q, da, db, oa, ob;
   int         fails = 0, num_checks = 0, cycles = 0, n, dv;
   int         ram [128];
   ram_io_timer_combo dut (.sys_clk(sys_clk), .nrst(nrst), .chipSelect(chipSelect), .nRamSelect(nRamSelect),
      .readNotWrite(readNotWrite), .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
      .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut),
      .portBOe(portBOe), .irqOut(irqOut), .irqOe(irqOe));
   host_bus_model host (.sys_clk(sys_clk), .chipSelect(chipSelect), .nRamSelect(nRamSelect),
      .readNotWrite(readNotWrite), .addr(addr), .dataIn(dataIn), .dataOut(dataOut));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic io, input logic [6:0] a, input logic [7:0] d);
      host.access(io, 1'b0, a, d, q);
   endtask
   task automatic rd(input logic io, input logic [6:0] a);
      host.access(io, 1'b1, a, 8'h00, q);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Ceiling sits well above the slowest timer case
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(32'h0000_8af4));
      nrst = 1'b1;
      portAIn = 8'h80;
      portBIn = 8'h00;
      // Fall after time zero so the reset edge is not lost in a start-up race
      #5;
      nrst = 1'b0;
      repeat (12) @(negedge sys_clk);
      check("dirA", 8'h00, portAOe);
      check("dirB", 8'h00, portBOe);
      check("oes", 8'h00, {6'h00, dataOe, irqOe});
      nrst = 1'b1;
      $display("reset done");
      for (int i = 0; i < 128; i++) begin
         ram[i] = $urandom & 255;
         wr(1'b0, i[6:0], ram[i][7:0]);
      end
      for (int i = 0; i < 128; i++) begin
         rd(1'b0, i[6:0]);
         check("ram", ram[i][7:0], q);
      end
      $display("ram done");
      for (int i = 0; i < 4; i++) begin
         {da, db, oa, ob} = $urandom;
         portBIn = 8'($urandom);
         wr(1'b1, 7'h01, da);
         wr(1'b1, 7'h00, oa);
         wr(1'b1, 7'h03, db);
         wr(1'b1, 7'h02, ob);
         check("outA", oa, portAOut);
         check("dirB", db, portBOe);
         rd(1'b1, 7'h00);
         check("pinA", portAIn, q);
         rd(1'b1, 7'h02);
         check("pinB", (ob & db) | (portBIn & ~db), q);
      end
      $display("ports done");
      for (int k = 0; k < 4; k++) begin
         dv = (k == 3) ? 1024 : 1 << (3 * k);
         wr(1'b1, {4'h1, 1'b1, k[1:0]}, 8'h02);
         n = 0;
         while (irqOe !== 1'b1 && n < 2 * dv + 10) begin
            @(negedge sys_clk);
            n++;
         end
         check("tmo", 8'h01, {7'h00, n == 2 * dv + 1});
         rd(1'b1, 7'h05);
         check("tflag", 8'h80, q & 8'h80);
         // Past timeout the count falls one per clock from all ones
         rd(1'b1, 7'h04);
         check("tcount", 8'hfc, q);
         wr(1'b1, 7'h04, 8'hff);
         check("irqoff", 8'h00, {7'h00, irqOe});
      end
      $display("timer done");
      wr(1'b1, 7'h10, 8'h00);
      portAIn = 8'h00;
      repeat (6) @(negedge sys_clk);
      rd(1'b1, 7'h05);
      check("edge", 8'h40, q & 8'h40);
      check("eirq", 8'h00, {7'h00, irqOe});
      rd(1'b1, 7'h05);
      check("eclr", 8'h00, q & 8'h40);
      wr(1'b1, 7'h13, 8'h00);
      portAIn = 8'h80;
      repeat (6) @(negedge sys_clk);
      check("eirqon", 8'h01, {7'h00, irqOe});
      rd(1'b1, 7'h05);
      check("erise", 8'h40, q & 8'h40);
      check("eirqoff", 8'h00, {7'h00, irqOe});
      $display("edge done");
      nrst = 1'b0;
      @(negedge sys_clk);
      check("rstA", 8'h00, portAOe | portAOut);
      check("rstB", 8'h00, portBOe | portBOut);
      nrst = 1'b1;
      $display("rerun reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire

// file: verilog/ram_io_timer_combo.sv
// Notes on behaviour
// - 128-byte RAM, host reads and writes
// - Two 8-bit ports, software sets direction, value
// - Interval timer, 1 to 261121 clocks, interrupts
// - Edge interrupt with programmable sensitivity
// - Reset clears directions and output latches
// - After reset every port line is input
// - Data bus floats during reset
// - Reset disables interrupts, request inactive
// - Everything runs on the single system clock
// - High reads, low writes when selected
// - Direction bit zero input, one output
// - Data bus driven only during reads
// - Open-drain low request from edge or timer
`timescale 1ns/1ps
`default_nettype none
`include "ram_io_timer_combo_defines.svh"
module ram_io_timer_combo
   import ram_io_timer_combo_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       chipSelect,
   input  wire logic       nRamSelect,
   input  wire logic       readNotWrite,
   input  wire logic [6:0] addr,
   input  wire logic [7:0] dataIn,
   output logic      [7:0] dataOut,
   output logic            dataOe,
   input  wire logic [7:0] portAIn,
   output logic      [7:0] portAOut,
   output logic      [7:0] portAOe,
   input  wire logic [7:0] portBIn,
   output logic      [7:0] portBOut,
   output logic      [7:0] portBOe,
   output logic            irqOut,
   output logic            irqOe
);
   logic [7:0] ram [0:127];
   logic [7:0] port_a_direction, port_b_direction;
   logic [7:0] port_a_output_latch, port_b_output_latch;
   logic [7:0] next_port_a_direction, next_port_b_direction;
   logic [7:0] next_port_a_output_latch, next_port_b_output_latch;
   logic [7:0] syncA1, syncA2, syncA3, syncB1, syncB2, syncB3;
   logic [7:0] pinA, pinB, next_pinA, next_pinB;
   logic [7:0] timerCount, next_timerCount;
   logic [9:0] prescale, next_prescale;
   divider_type divider, next_divider;
   logic timerFlag, next_timerFlag, timerIrqEn, next_timerIrqEn;
   logic edgeFlag, next_edgeFlag, edgeIrqEn, next_edgeIrqEn;
   logic edgeRising, next_edgeRising, edgeLast, next_edgeLast;
   logic [7:0] next_dataOut;
   logic       next_dataOe;
   logic busRead, busWrite, ioAccess, timerAccess, tick, edgeSeen;
   port_drive_type driveA, driveB;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign busRead     = chipSelect & readNotWrite;
   assign busWrite    = chipSelect & ~readNotWrite;
   assign ioAccess    = nRamSelect;
   assign timerAccess = ioAccess & addr[`ADDR_TIMER_BIT];

   // ----------------------------------------------------------------
   // RAM
   // ----------------------------------------------------------------
   // Memory has no reset, so it stays outside the reset process
   always_ff @(posedge sys_clk) begin
      if (busWrite && !ioAccess) begin
         ram[addr] <= dataIn;
      end
   end

   // ----------------------------------------------------------------
   // Port input sampling
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         syncA1 <= 8'h00;
         syncA2 <= 8'h00;
         syncA3 <= 8'h00;
         syncB1 <= 8'h00;
         syncB2 <= 8'h00;
         syncB3 <= 8'h00;
         pinA   <= 8'h00;
         pinB   <= 8'h00;
      end else begin
         syncA1 <= portAIn;
         syncA2 <= syncA1;
         syncA3 <= syncA2;
         syncB1 <= portBIn;
         syncB2 <= syncB1;
         syncB3 <= syncB2;
         pinA   <= next_pinA;
         pinB   <= next_pinB;
      end
   end

   // A bit updates only once the last two stages agree
   always_comb begin
      next_pinA = (~(syncA2 ^ syncA3) & syncA2) | ((syncA2 ^ syncA3) & pinA);
      next_pinB = (~(syncB2 ^ syncB3) & syncB2) | ((syncB2 ^ syncB3) & pinB);
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_port_a_direction    = port_a_direction;
      next_port_b_direction    = port_b_direction;
      next_port_a_output_latch = port_a_output_latch;
      next_port_b_output_latch = port_b_output_latch;
      next_divider     = divider;
      next_timerIrqEn  = timerIrqEn;
      next_edgeIrqEn   = edgeIrqEn;
      next_edgeRising  = edgeRising;
      next_edgeLast    = pinA[7];
      next_dataOut     = dataOut;
      next_dataOe      = 1'b0;
      tick = 1'b0;
      case (divider)
         DIV_1:    tick = 1'b1;
         DIV_8:    tick = (prescale[2:0] == 3'h0);
         DIV_64:   tick = (prescale[5:0] == 6'h00);
         DIV_1024: tick = (prescale == 10'h000);
         default:  tick = 1'b1;
      endcase
      // After timeout the counter runs at the undivided rate
      if (timerFlag) begin
         tick = 1'b1;
      end
      next_prescale   = prescale - 10'h001;
      next_timerCount = tick ? timerCount - 8'h01 : timerCount;
      next_timerFlag  = timerFlag | (tick && timerCount == 8'h00);
      edgeSeen = edgeRising ? (pinA[7] & ~edgeLast) : (~pinA[7] & edgeLast);
      next_edgeFlag   = edgeFlag | edgeSeen;

      if (busWrite && ioAccess) begin
         if (timerAccess) begin
            next_timerCount = dataIn;
            next_divider    = divider_type'(addr[1:0]);
            // Cleared prescaler puts the first count one clock after the load
            next_prescale   = `PRESCALE_RESET;
            next_timerIrqEn = addr[`ADDR_IRQ_EN_BIT];
            next_timerFlag  = 1'b0;
         end else if (addr[`ADDR_EDGE_SEL_BIT]) begin
            next_edgeRising = addr[`ADDR_EDGE_POL_BIT];
            next_edgeIrqEn  = addr[`ADDR_EDGE_EN_BIT];
         end else if (addr[2:0] == `SEL_PORT_A_DATA) begin
            next_port_a_output_latch = dataIn;
         end else if (addr[2:0] == `SEL_PORT_A_DIR) begin
            next_port_a_direction = dataIn;
         end else if (addr[2:0] == `SEL_PORT_B_DATA) begin
            next_port_b_output_latch = dataIn;
         end else begin
            next_port_b_direction = dataIn;
         end
      end

      if (busRead) begin
         next_dataOe = 1'b1;
         if (!ioAccess) begin
            next_dataOut = ram[addr];
         end else if (timerAccess && !addr[0]) begin
            next_dataOut    = timerCount;
            next_timerIrqEn = addr[`ADDR_IRQ_EN_BIT];
            // A timeout landing on the read itself is kept
            if (!(tick && timerCount == 8'h00)) begin
               next_timerFlag = 1'b0;
            end
         end else if (timerAccess) begin
            next_dataOut = {timerFlag, edgeFlag, 6'h00};
            next_edgeFlag = edgeSeen;
         end else if (addr[2:0] == `SEL_PORT_A_DATA) begin
            next_dataOut = pinA;
         end else if (addr[2:0] == `SEL_PORT_A_DIR) begin
            next_dataOut = port_a_direction;
         end else if (addr[2:0] == `SEL_PORT_B_DATA) begin
            // Output lines read back the latch, not the loaded pin
            next_dataOut = (port_b_output_latch & port_b_direction) | (pinB & ~port_b_direction);
         end else begin
            next_dataOut = port_b_direction;
         end
      end
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         port_a_direction    <= `PORT_RESET;
         port_b_direction    <= `PORT_RESET;
         port_a_output_latch <= `PORT_RESET;
         port_b_output_latch <= `PORT_RESET;
         timerCount <= `TIMER_RESET;
         prescale   <= `PRESCALE_RESET;
         divider    <= DIV_1;
         timerFlag  <= 1'b0;
         timerIrqEn <= 1'b0;
         edgeFlag   <= 1'b0;
         edgeIrqEn  <= 1'b0;
         edgeRising <= 1'b0;
         edgeLast   <= 1'b0;
         dataOut    <= 8'h00;
         dataOe     <= 1'b0;
      end else begin
         port_a_direction    <= next_port_a_direction;
         port_b_direction    <= next_port_b_direction;
         port_a_output_latch <= next_port_a_output_latch;
         port_b_output_latch <= next_port_b_output_latch;
         timerCount <= next_timerCount;
         prescale   <= next_prescale;
         divider    <= next_divider;
         timerFlag  <= next_timerFlag;
         timerIrqEn <= next_timerIrqEn;
         edgeFlag   <= next_edgeFlag;
         edgeIrqEn  <= next_edgeIrqEn;
         edgeRising <= next_edgeRising;
         edgeLast   <= next_edgeLast;
         dataOut    <= next_dataOut;
         dataOe     <= next_dataOe;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   assign driveA = '{value: port_a_output_latch, enable: port_a_direction};
   assign driveB = '{value: port_b_output_latch, enable: port_b_direction};
   assign portAOut = driveA.value;
   assign portAOe  = driveA.enable;
   assign portBOut = driveB.value;
   assign portBOe  = driveB.enable;
   assign irqOut   = 1'b0;
   assign irqOe    = (timerFlag & timerIrqEn) | (edgeFlag & edgeIrqEn);

endmodule
`default_nettype wire

// file: verilog/ram_io_timer_combo_defines.svh
`ifndef RAM_IO_TIMER_COMBO_DEFINES_SVH
`define RAM_IO_TIMER_COMBO_DEFINES_SVH
// Register select codes on addr[2:0] when the I/O space is chosen
`define SEL_PORT_A_DATA  3'h0
`define SEL_PORT_A_DIR   3'h1
`define SEL_PORT_B_DATA  3'h2
`define SEL_PORT_B_DIR   3'h3
// Field positions in the address and in the status byte
`define ADDR_TIMER_BIT   2
`define ADDR_IRQ_EN_BIT  3
`define ADDR_EDGE_POL_BIT 0
`define ADDR_EDGE_EN_BIT 1
`define ADDR_EDGE_SEL_BIT 4
`define FLAG_TIMER_BIT   7
`define FLAG_EDGE_BIT    6
// Reset values
`define PORT_RESET       8'h00
`define TIMER_RESET      8'hFF
`define PRESCALE_RESET   10'h000
`endif

// file: verilog/ram_io_timer_combo_pkg.sv
package ram_io_timer_combo_pkg;
   typedef struct packed {
      logic [7:0] value;
      logic [7:0] enable;
   } port_drive_type;
   typedef enum logic [1:0] {
      DIV_1,
      DIV_8,
      DIV_64,
      DIV_1024
   } divider_type;
endpackage
